// ---- src/vec_pkg.sv ----
// Constants, field layouts and carrier types for the vendor capability bank.
// Assumes a 12-bit configuration-space byte address and 32-bit data words.
package vec_pkg;

  // Word offsets within configuration space
  localparam logic [11:0] VEC_OFS_CAP_HDR    = 12'h200;
  localparam logic [11:0] VEC_OFS_VND_HDR    = 12'h204;
  localparam logic [11:0] VEC_OFS_MARKER     = 12'h208;
  localparam logic [11:0] VEC_OFS_SID_W0     = 12'h20C;
  localparam logic [11:0] VEC_OFS_SID_W1     = 12'h210;
  localparam logic [11:0] VEC_OFS_SID_W2     = 12'h214;
  localparam logic [11:0] VEC_OFS_SID_W3     = 12'h218;
  localparam logic [11:0] VEC_OFS_LOAD_STAT  = 12'h21C;
  localparam logic [11:0] VEC_OFS_MODE_CTRL  = 12'h220;
  localparam logic [11:0] VEC_OFS_LOAD_DATA  = 12'h228;
  localparam logic [11:0] VEC_OFS_PROG_CTRL  = 12'h22C;
  localparam logic [11:0] VEC_OFS_RSVD       = 12'h230;
  localparam logic [11:0] VEC_OFS_FATAL_ST   = 12'h234;
  localparam logic [11:0] VEC_OFS_FATAL_MSK  = 12'h238;
  localparam logic [11:0] VEC_OFS_SOFT_ST    = 12'h23C;
  localparam logic [11:0] VEC_OFS_SOFT_MSK   = 12'h240;

  // Fixed header values
  localparam logic [15:0] VEC_EXT_CAP_ID     = 16'h000B;
  localparam logic [3:0]  VEC_CAP_VERSION    = 4'h1;
  localparam logic [11:0] VEC_STRUCT_LENGTH  = 12'h044;

  // Load status word: board type low half, status bits from 16 up
  localparam int          VEC_STAT_POS       = 16;
  localparam int          VEC_STAT_W         = 10;
  localparam int          VEC_STAT_EN_BIT    = 4;

  // Mode control field positions
  localparam int          VEC_MC_MODE_BIT    = 0;
  localparam int          VEC_MC_CLKSEL_BIT  = 1;
  localparam int          VEC_MC_FULL_BIT    = 2;
  localparam int          VEC_MC_NCLK_POS    = 8;
  localparam int          VEC_MC_NCLK_W      = 8;

  // Reset values of writable state
  localparam logic [7:0]  VEC_RST_NCLK       = 8'h00;
  localparam logic        VEC_RST_BIT        = 1'b0;
  localparam logic [31:0] VEC_RST_WORD       = 32'h0000_0000;

  // Configuration request from the host side
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } vec_cfg_req_s;

  // Configuration answer to the host side
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } vec_cfg_rsp_s;

  // Mode control fields as driven to the loader
  typedef struct packed {
    logic [7:0] numClks;
    logic       fullConfig;
    logic       clkSel;
    logic       modeActive;
  } vec_mode_s;

  // Merge write data into an old word under byte enables
  function automatic logic [31:0] vec_be_merge(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = oldWord;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = newWord[i*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage

// ---- src/vec_sync2.sv ----
// Two-flop synchroniser for a bus of independent level signals.
// Assumes each bit is a slow level; no coherence between bits.
`timescale 1ns/1ps
module vec_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Levels in and out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // vec_sync2

// ---- src/vec_w1c_reg.sv ----
// Sticky status word: hardware sets, software clears by writing ones.
// Assumes set and clear are one-cycle terms on the same clock.
`timescale 1ns/1ps
module vec_w1c_reg #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // Events and clear mask
  input  wire logic [WIDTH-1:0] setBits,
  input  wire logic [WIDTH-1:0] clrBits,
  // Held status
  output logic      [WIDTH-1:0] status_q
);

  logic [WIDTH-1:0] status_d;

  // A set in the clearing cycle survives
  assign status_d = (status_q & ~clrBits) | setBits;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

endmodule // vec_w1c_reg

// ---- src/vec_cap_regs.sv ----
// Vendor extended capability bank: headers, identifiers, load control
// and internal error registers in configuration space.
// Assumes one configuration request at a time from the core, on clock.
`timescale 1ns/1ps
module vec_cap_regs
  import vec_pkg::*;
#(
  // Build-time identity values; defaults are arbitrary
  parameter logic [11:0]  NEXT_CAP_OFS = 12'h000,
  parameter logic [15:0]  VENDOR_ID    = 16'h1234,
  parameter logic [3:0]   VENDOR_REV   = 4'h0,
  parameter logic [31:0]  MARKER_VAL   = 32'h5A5A_0001,
  parameter logic [127:0] SILICON_ID   = 128'h0000_0004_0000_0003_0000_0002_0000_0001,
  parameter logic [15:0]  BOARD_TYPE   = 16'h0001
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  // Configuration request and answer
  input  wire vec_pkg::vec_cfg_req_s cfgReq,
  output vec_pkg::vec_cfg_rsp_s      cfgRsp,
  // Loader status levels from the fabric control block
  input  wire logic [9:0]            loadStatusIn,
  // Loader controls
  output vec_pkg::vec_mode_s         modeCtrl,
  output logic [31:0]                loadData,
  output logic                       loadDataWrite,
  output logic [31:0]                progCtrl,
  // Internal error events
  input  wire logic [31:0]           fatalErrEvent,
  input  wire logic [31:0]           softErrEvent,
  // Unmasked error summaries
  output logic                       fatalErrPending,
  output logic                       softErrPending
);

  // Synchronised loader status
  logic [VEC_STAT_W-1:0] loadStatSync;

  vec_sync2 #(
    .WIDTH (VEC_STAT_W)
  ) u_stat_sync (
    .clock   (clock),
    .resetn  (resetn),
    .asyncIn (loadStatusIn),
    .syncOut (loadStatSync)
  );

  // Address decode
  logic hitCapHdr;
  logic hitVndHdr;
  logic hitMarker;
  logic hitSid0;
  logic hitSid1;
  logic hitSid2;
  logic hitSid3;
  logic hitStat;
  logic hitMode;
  logic hitData;
  logic hitProg;
  logic hitRsvd;
  logic hitFatalSt;
  logic hitFatalMsk;
  logic hitSoftSt;
  logic hitSoftMsk;
  logic wrEn;
  logic [11:0] wordAddr;

  assign wordAddr    = {cfgReq.addr[11:2], 2'b00};
  assign wrEn        = cfgReq.wr;
  assign hitCapHdr   = (wordAddr == VEC_OFS_CAP_HDR);
  assign hitVndHdr   = (wordAddr == VEC_OFS_VND_HDR);
  assign hitMarker   = (wordAddr == VEC_OFS_MARKER);
  assign hitSid0     = (wordAddr == VEC_OFS_SID_W0);
  assign hitSid1     = (wordAddr == VEC_OFS_SID_W1);
  assign hitSid2     = (wordAddr == VEC_OFS_SID_W2);
  assign hitSid3     = (wordAddr == VEC_OFS_SID_W3);
  assign hitStat     = (wordAddr == VEC_OFS_LOAD_STAT);
  assign hitMode     = (wordAddr == VEC_OFS_MODE_CTRL);
  assign hitData     = (wordAddr == VEC_OFS_LOAD_DATA);
  assign hitProg     = (wordAddr == VEC_OFS_PROG_CTRL);
  assign hitRsvd     = (wordAddr == VEC_OFS_RSVD);
  assign hitFatalSt  = (wordAddr == VEC_OFS_FATAL_ST);
  assign hitFatalMsk = (wordAddr == VEC_OFS_FATAL_MSK);
  assign hitSoftSt   = (wordAddr == VEC_OFS_SOFT_ST);
  assign hitSoftMsk  = (wordAddr == VEC_OFS_SOFT_MSK);

  // Fixed words built from constants and build-time values
  logic [31:0] capHdrWord;
  logic [31:0] vndHdrWord;
  logic [31:0] statWord;

  assign capHdrWord[15:0]  = VEC_EXT_CAP_ID;
  assign capHdrWord[19:16] = VEC_CAP_VERSION;
  assign capHdrWord[31:20] = NEXT_CAP_OFS;
  assign vndHdrWord[15:0]  = VENDOR_ID;
  assign vndHdrWord[19:16] = VENDOR_REV;
  assign vndHdrWord[31:20] = VEC_STRUCT_LENGTH;

  // Board type low, status bits above, rest of upper half zero
  assign statWord[15:0] = BOARD_TYPE;
  assign statWord[VEC_STAT_POS +: VEC_STAT_W] = loadStatSync;
  assign statWord[31:VEC_STAT_POS+VEC_STAT_W] = '0;

  // Mode control register
  logic [7:0] numClks_q;
  logic [7:0] numClks_d;
  logic       fullCfg_q;
  logic       fullCfg_d;
  logic       clkSel_q;
  logic       clkSel_d;
  logic       modeAct_q;
  logic       modeAct_d;
  logic       modeWr;
  logic       modeReq;
  logic [31:0] modeWord;

  assign modeWr  = wrEn & hitMode;
  // Load mode may only turn on while the control block enables it
  assign modeReq = cfgReq.wdata[VEC_MC_MODE_BIT] &
                   loadStatSync[VEC_STAT_EN_BIT];
  assign numClks_d = (modeWr & cfgReq.be[1]) ?
                     cfgReq.wdata[VEC_MC_NCLK_POS +: VEC_MC_NCLK_W] :
                     numClks_q;
  assign fullCfg_d = (modeWr & cfgReq.be[0]) ?
                     cfgReq.wdata[VEC_MC_FULL_BIT] : fullCfg_q;
  assign clkSel_d  = (modeWr & cfgReq.be[0]) ?
                     cfgReq.wdata[VEC_MC_CLKSEL_BIT] : clkSel_q;
  assign modeAct_d = (modeWr & cfgReq.be[0]) ? modeReq : modeAct_q;

  always_comb begin
    modeWord = '0;
    modeWord[VEC_MC_NCLK_POS +: VEC_MC_NCLK_W] = numClks_q;
    modeWord[VEC_MC_FULL_BIT]   = fullCfg_q;
    modeWord[VEC_MC_CLKSEL_BIT] = clkSel_q;
    modeWord[VEC_MC_MODE_BIT]   = modeAct_q;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      numClks_q <= VEC_RST_NCLK;
      fullCfg_q <= VEC_RST_BIT;
      clkSel_q  <= VEC_RST_BIT;
      modeAct_q <= VEC_RST_BIT;
    end else begin
      numClks_q <= numClks_d;
      fullCfg_q <= fullCfg_d;
      clkSel_q  <= clkSel_d;
      modeAct_q <= modeAct_d;
    end
  end

  // Data, program control and mask words
  logic [31:0] data_q;
  logic [31:0] data_d;
  logic        dataWr_q;
  logic [31:0] prog_q;
  logic [31:0] prog_d;
  logic [31:0] fatalMsk_q;
  logic [31:0] fatalMsk_d;
  logic [31:0] softMsk_q;
  logic [31:0] softMsk_d;

  assign data_d = (wrEn & hitData) ?
                  vec_be_merge(data_q, cfgReq.wdata, cfgReq.be) : data_q;
  assign prog_d = (wrEn & hitProg) ?
                  vec_be_merge(prog_q, cfgReq.wdata, cfgReq.be) : prog_q;
  assign fatalMsk_d = (wrEn & hitFatalMsk) ?
                      vec_be_merge(fatalMsk_q, cfgReq.wdata, cfgReq.be) :
                      fatalMsk_q;
  assign softMsk_d  = (wrEn & hitSoftMsk) ?
                      vec_be_merge(softMsk_q, cfgReq.wdata, cfgReq.be) :
                      softMsk_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_q     <= VEC_RST_WORD;
      dataWr_q   <= 1'b0;
      prog_q     <= VEC_RST_WORD;
      fatalMsk_q <= VEC_RST_WORD;
      softMsk_q  <= VEC_RST_WORD;
    end else begin
      data_q     <= data_d;
      dataWr_q   <= wrEn & hitData;
      prog_q     <= prog_d;
      fatalMsk_q <= fatalMsk_d;
      softMsk_q  <= softMsk_d;
    end
  end

  // Error status words, cleared by writing ones under byte enables
  logic [31:0] beMask;
  logic [31:0] fatalClr;
  logic [31:0] softClr;
  logic [31:0] fatalSt;
  logic [31:0] softSt;

  assign beMask   = {{8{cfgReq.be[3]}}, {8{cfgReq.be[2]}},
                     {8{cfgReq.be[1]}}, {8{cfgReq.be[0]}}};
  assign fatalClr = (wrEn & hitFatalSt) ? (cfgReq.wdata & beMask) : '0;
  assign softClr  = (wrEn & hitSoftSt)  ? (cfgReq.wdata & beMask) : '0;

  vec_w1c_reg #(
    .WIDTH (32)
  ) u_fatal_st (
    .clock    (clock),
    .resetn   (resetn),
    .setBits  (fatalErrEvent),
    .clrBits  (fatalClr),
    .status_q (fatalSt)
  );

  vec_w1c_reg #(
    .WIDTH (32)
  ) u_soft_st (
    .clock    (clock),
    .resetn   (resetn),
    .setBits  (softErrEvent),
    .clrBits  (softClr),
    .status_q (softSt)
  );

  // Read mux; read-only, reserved and unmapped words need no write path
  logic [31:0] rdMux;

  always_comb begin
    rdMux = '0;
    if (hitCapHdr) begin
      rdMux = capHdrWord;
    end else if (hitVndHdr) begin
      rdMux = vndHdrWord;
    end else if (hitMarker) begin
      rdMux = MARKER_VAL;
    end else if (hitSid0) begin
      rdMux = SILICON_ID[31:0];
    end else if (hitSid1) begin
      rdMux = SILICON_ID[63:32];
    end else if (hitSid2) begin
      rdMux = SILICON_ID[95:64];
    end else if (hitSid3) begin
      rdMux = SILICON_ID[127:96];
    end else if (hitStat) begin
      rdMux = statWord;
    end else if (hitMode) begin
      rdMux = modeWord;
    end else if (hitData) begin
      rdMux = data_q;
    end else if (hitProg) begin
      rdMux = prog_q;
    end else if (hitRsvd) begin
      rdMux = '0;
    end else if (hitFatalSt) begin
      rdMux = fatalSt;
    end else if (hitFatalMsk) begin
      rdMux = fatalMsk_q;
    end else if (hitSoftSt) begin
      rdMux = softSt;
    end else if (hitSoftMsk) begin
      rdMux = softMsk_q;
    end
  end

  // Every request, read-only targets included, is answered next cycle
  logic        reqValid;
  logic [31:0] rdata_d;

  assign reqValid = cfgReq.rd | cfgReq.wr;
  assign rdata_d  = cfgReq.rd ? rdMux : '0;

  // Answer and summary flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfgRsp          <= '0;
      fatalErrPending <= 1'b0;
      softErrPending  <= 1'b0;
    end else begin
      cfgRsp.ack      <= reqValid;
      cfgRsp.rdata    <= rdata_d;
      fatalErrPending <= |(fatalSt & ~fatalMsk_q);
      softErrPending  <= |(softSt & ~softMsk_q);
    end
  end

  // Loader controls straight from their registers
  assign modeCtrl.numClks    = numClks_q;
  assign modeCtrl.fullConfig = fullCfg_q;
  assign modeCtrl.clkSel     = clkSel_q;
  assign modeCtrl.modeActive = modeAct_q;
  assign loadData            = data_q;
  assign loadDataWrite       = dataWr_q;
  assign progCtrl            = prog_q;

endmodule // vec_cap_regs

// ---- sim/vec_cap_props.sv ----
// Checker for the vendor capability bank, bound to its ports.
// Assumes one clock domain and the one-cycle answer of the bank.
`timescale 1ns/1ps
module vec_cap_props #(
  parameter logic [11:0] NEXT_CAP_OFS = 12'h000,
  parameter logic [15:0] BOARD_TYPE   = 16'h0001
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  resetn,
  // Request and answer
  input wire vec_pkg::vec_cfg_req_s cfgReq,
  input wire vec_pkg::vec_cfg_rsp_s cfgRsp,
  // Data register outputs
  input wire logic [31:0]           loadData,
  input wire logic                  loadDataWrite
);
  import vec_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Read or write taken at one word
  sequence rd_at(logic [11:0] a);
    cfgReq.rd && {cfgReq.addr[11:2], 2'b00} == a;
  endsequence
  sequence wr_at(logic [11:0] a);
    cfgReq.wr && {cfgReq.addr[11:2], 2'b00} == a;
  endsequence
  hdr_read_a: assert property (rd_at(12'h200) |=>
    cfgRsp.rdata == {NEXT_CAP_OFS, 4'h1, 16'h000B})
    else $error("capability header read wrong");
  vhdr_len_a: assert property (rd_at(12'h204) |=>
    cfgRsp.rdata[31:20] == 12'h044)
    else $error("structure length read wrong");
  stat_read_a: assert property (rd_at(12'h21C) |=>
    cfgRsp.rdata[15:0] == BOARD_TYPE && cfgRsp.rdata[31:26] == 6'h00)
    else $error("board type word read wrong");
  rsvd_zero_a: assert property (rd_at(12'h230) |=>
    cfgRsp.rdata == 32'h0)
    else $error("reserved word not zero");
  ack_timing_a: assert property ((cfgReq.rd || cfgReq.wr) |=>
    cfgRsp.ack)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (cfgRsp.ack |->
    $past(cfgReq.rd) || $past(cfgReq.wr))
    else $error("answer without request");
  wr_quiet_a: assert property (cfgReq.wr && !cfgReq.rd |=>
    cfgRsp.ack && cfgRsp.rdata == 32'h0)
    else $error("write answer carries data");
  data_pulse_a: assert property (wr_at(12'h228) ##0 cfgReq.be == 4'hF |=>
    loadDataWrite && loadData == $past(cfgReq.wdata))
    else $error("data register write not passed on");
  pulse_cause_a: assert property (loadDataWrite |-> $past(cfgReq.wr) &&
    $past(cfgReq.addr) inside {[12'h228:12'h22B]})
    else $error("data pulse without data write");
endmodule // vec_cap_props

bind vec_cap_regs vec_cap_props #(
  .NEXT_CAP_OFS(NEXT_CAP_OFS),
  .BOARD_TYPE  (BOARD_TYPE)
) i_vec_cap_props (
  .clock        (clock),
  .resetn       (resetn),
  .cfgReq       (cfgReq),
  .cfgRsp       (cfgRsp),
  .loadData     (loadData),
  .loadDataWrite(loadDataWrite)
);

// ---- sim/vec_host_model.sv ----
// Host model: issues configuration requests one at a time.
// Assumes the bank answers one clock after it takes a request.
`timescale 1ns/1ps
module vec_host_model (
  // Clock
  input  wire logic                  clock,
  // Request out, answer in
  output vec_pkg::vec_cfg_req_s      cfgReq,
  input  wire vec_pkg::vec_cfg_rsp_s cfgRsp
);
  import vec_pkg::*;
  initial cfgReq = '0;
  // One-cycle request after an idle gap; answer sampled 1 ns after the request is released
  task automatic xfer(input logic rd, wr, input logic [11:0] addr,
                      input logic [3:0] be, input logic [31:0] wd,
                      input int gap, output logic ack,
                      output logic [31:0] rdat);
    repeat (gap + 1) @(posedge clock);
    cfgReq <= '{rd, wr, addr, be, wd};
    @(posedge clock);
    // Released address, enables and data carry the inverse, never the last value; rd and wr drop to zero
    cfgReq <= '{1'b0, 1'b0, ~addr, ~be, ~wd};
    #1;
    ack = cfgRsp.ack;
    rdat = cfgRsp.rdata;
  endtask
endmodule // vec_host_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the vendor capability bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_top;
  import vec_pkg::*;
  // Identity values below are arbitrary
  localparam logic [11:0]  NXT = 12'h48C;
  localparam logic [15:0]  VID = 16'hC3A5;
  localparam logic [3:0]   VRV = 4'h6;
  localparam logic [31:0]  MRK = 32'h0BAD_F00D;
  localparam logic [127:0] SID =
    128'h1111_2222_3333_4444_5555_6666_7777_8888;
  localparam logic [15:0]  BRD = 16'h00E7;
  logic         clock         = 1'b0;
  logic         resetn        = 1'b0;
  logic [9:0]   loadStatusIn  = 10'h000;
  logic [31:0]  fatalErrEvent = 32'h0;
  logic [31:0]  softErrEvent  = 32'h0;
  vec_cfg_req_s cfgReq;
  vec_cfg_rsp_s cfgRsp;
  vec_mode_s    modeCtrl;
  logic [31:0]  loadData;
  logic [31:0]  progCtrl;
  logic         loadDataWrite;
  logic         fatalErrPending;
  logic         softErrPending;
  integer       seed          = 32'h7d23_afaa;
  int           err_total     = 0;
  int           tests_run     = 0;
  // Clock, 10 ns period
  always #5 clock = ~clock;
  vec_cap_regs #(
    .NEXT_CAP_OFS(NXT), .VENDOR_ID(VID), .VENDOR_REV(VRV),
    .MARKER_VAL(MRK), .SILICON_ID(SID), .BOARD_TYPE(BRD)
  ) i_vec_cap_regs (
    .clock, .resetn, .cfgReq, .cfgRsp, .loadStatusIn, .modeCtrl,
    .loadData, .loadDataWrite, .progCtrl, .fatalErrEvent,
    .softErrEvent, .fatalErrPending, .softErrPending
  );
  vec_host_model i_vec_host_model (.clock, .cfgReq, .cfgRsp);
  // Expected contents of the fixed words
  function automatic logic [31:0] exp_ro(input logic [11:0] a);
    case (a)
      12'h200: return {NXT, 4'h1, 16'h000B};
      12'h204: return {12'h044, VRV, VID};
      12'h208: return MRK;
      12'h21C: return {6'h00, loadStatusIn, BRD};
      default: return SID[int'(a - 12'h20C) * 8 +: 32];
    endcase
  endfunction
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One access through the host with a random idle gap
  task automatic acc(input logic rd, wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat);
    logic ack;
    i_vec_host_model.xfer(rd, wr, a, 4'hF, wd,
                          int'($unsigned($random(seed)) % 3), ack, rdat);
    chk("ack", {31'h0, ack}, 32'h1);
  endtask
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Guard against a hang
  initial begin
    #200_000;
    err_total++;
    summarize();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [31:0] v;
    logic [31:0] old;
    logic [31:0] e;
    logic [11:0] b;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    // Writable, unmapped and reserved words read zero after reset
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 1'b0, 12'h220 + 12'(i * 4), 32'h0, r);
      chk("reset word", r, 32'h0);
    end
    $display("test reset values done");
    @(posedge clock);
    loadStatusIn <= 10'($random(seed));
    repeat (3) @(posedge clock);
    // Fixed words ignore writes
    for (b = 12'h200; b < 12'h220; b += 12'h004) begin
      acc(1'b0, 1'b1, b, $random(seed), r);
      acc(1'b1, 1'b0, b, 32'h0, r);
      chk("fixed word", r, exp_ro(b));
    end
    acc(1'b0, 1'b1, 12'h230, $random(seed), r);
    acc(1'b1, 1'b0, 12'h230, 32'h0, r);
    chk("reserved word", r, 32'h0);
    $display("test fixed words done");
    old = 32'h0;
    for (int k = 0; k < 4; k++) begin
      v = $random(seed) | 32'h0000_0001;
      @(posedge clock);
      loadStatusIn <= {v[9:5], k[0], v[3:0]};
      repeat (3) @(posedge clock);
      // Read with write: old data back, new data held and announced
      acc(1'b1, 1'b1, 12'h228, v, r);
      chk("data old", r, old);
      chk("data out", loadData, v);
      chk("data pulse", {31'h0, loadDataWrite}, 32'h1);
      old = v;
      acc(1'b0, 1'b1, 12'h22C, ~v, r);
      chk("prog out", progCtrl, ~v);
      acc(1'b0, 1'b1, 12'h220, v, r);
      e = {16'h0000, v[15:8], 5'h00, v[2:1], v[0] & k[0]};
      chk("mode out", {21'h0, modeCtrl}, {21'h0, e[15:8], e[2:0]});
      acc(1'b1, 1'b0, 12'h220, 32'h0, r);
      chk("mode word", r, e);
    end
    $display("test load control done");
    for (int j = 0; j < 2; j++) begin
      b = j ? 12'h23C : 12'h234;
      v = 32'h1 << ($unsigned($random(seed)) % 32);
      @(posedge clock);
      if (j) softErrEvent <= v;
      else fatalErrEvent <= v;
      @(posedge clock);
      fatalErrEvent <= 32'h0;
      softErrEvent  <= 32'h0;
      acc(1'b1, 1'b0, b, 32'h0, r);
      chk("err status", r, v);
      chk("err pending", {31'h0, j ? softErrPending : fatalErrPending}, 1);
      acc(1'b0, 1'b1, b + 12'h004, 32'hFFFF_FFFF, r);
      acc(1'b1, 1'b0, b + 12'h004, 32'h0, r);
      chk("err mask", r, 32'hFFFF_FFFF);
      chk("err masked", {31'h0, j ? softErrPending : fatalErrPending}, 0);
      acc(1'b0, 1'b1, b, v, r);
      acc(1'b1, 1'b0, b, 32'h0, r);
      chk("err cleared", r, 32'h0);
      acc(1'b0, 1'b1, b + 12'h004, 32'h0, r);
    end
    $display("test error words done");
    // Second reset in mid-run clears the data register
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    acc(1'b1, 1'b0, 12'h228, 32'h0, r);
    chk("data after reset", r, 32'h0);
    $display("test second reset done");
    summarize();
  end
endmodule // tb_top
